//--- design/isr_pkg.sv
package isr_pkg;
  localparam int SB_OVERLOAD_POS = 0;
  localparam int SB_MSG_AVAIL_POS = 4;
  localparam int SB_STD_EVENT_POS = 5;
  localparam int SB_MASTER_POS = 6;
  localparam int SB_OPERATION_POS = 7;
  localparam int SE_OP_COMPLETE_POS = 0;
  localparam int SE_REQ_CONTROL_POS = 1;
  localparam int SE_QUERY_ERR_POS = 2;
  localparam int SE_DEVICE_ERR_POS = 3;
  localparam int SE_EXEC_ERR_POS = 4;
  localparam int SE_SYNTAX_ERR_POS = 5;
  localparam int SE_USER_REQ_POS = 6;
  localparam int SE_POWER_ON_POS = 7;
  localparam int OC_CAL_POS = 0;
  localparam int OC_SWEEP_POS = 10;
  localparam int OC_SPOT_POS = 12;
  localparam logic [7:0] SE_RESET = 8'h80;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Register selector for host writes and reads
  typedef enum logic [3:0] {
    ISR_REG_SUMMARY = 4'h0,
    ISR_REG_SRE = 4'h1,
    ISR_REG_STDEVT = 4'h2,
    ISR_REG_ESE = 4'h3,
    ISR_REG_OPCOND = 4'h4,
    ISR_REG_OPEVT = 4'h5,
    ISR_REG_OPEN = 4'h6,
    ISR_REG_PTR = 4'h7,
    ISR_REG_NTR = 4'h8,
    ISR_REG_OVEVT = 4'h9,
    ISR_REG_OVEN = 4'ha
  } isr_reg_e;

  typedef struct packed {
    logic syntax_error;
    logic execution_error;
    logic device_error;
    logic query_error;
    logic op_complete;
  } isr_std_events_s;

  typedef struct packed {
    logic spot_busy;
    logic sweep_busy;
    logic cal_busy;
  } isr_op_status_s;
endpackage

//--- design/isr_event_reg.sv
`timescale 1ns/100ps
`default_nettype none
// Sticky event register with enable mask and summary
module isr_event_reg #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clear_in,
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic [WIDTH-1:0] event_out,
  output logic [WIDTH-1:0] enable_out,
  output logic summary_out
);
  logic [WIDTH-1:0] event_q;
  logic [WIDTH-1:0] event_d;
  logic [WIDTH-1:0] enable_q;

  // Set wins over a same-cycle clear so no event is lost
  assign event_d = (clear_in ? '0 : event_q) | set_in;
  assign event_out = event_q;
  assign enable_out = enable_q;
  assign summary_out = |(event_q & enable_q);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      event_q <= RESET_VAL;
      enable_q <= '0;
    end else begin
      event_q <= event_d;
      if (wr_en_in) begin
        enable_q <= wr_data_in;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/isr_status_top.sv
`timescale 1ns/100ps
`default_nettype none
module isr_status_top #(
  parameter int OP_WIDTH = 16,
  parameter int OV_WIDTH = 16
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire isr_pkg::isr_std_events_s std_events_in,
  input wire isr_pkg::isr_op_status_s op_status_in,
  input wire logic [OV_WIDTH-1:0] overload_events_in,
  input wire logic message_available_in,
  input wire logic clear_status_in,
  input wire logic serial_poll_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire isr_pkg::isr_reg_e reg_sel_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [7:0] poll_byte_out,
  output logic poll_valid_out,
  output logic service_request_out
);
  // Condition map and host data path are sized for 16-bit words
  if (OP_WIDTH != 16 || OV_WIDTH < 1 || OV_WIDTH > 16) begin : g_width_check
    $error("isr_status_top: unsupported register width");
  end

  // Condition inputs are generated on this clock; no synchroniser
  logic [OP_WIDTH-1:0] op_cond;
  logic [OP_WIDTH-1:0] op_cond_q;
  logic [OP_WIDTH-1:0] ptr_q;
  logic [OP_WIDTH-1:0] ntr_q;
  logic [OP_WIDTH-1:0] op_set;
  logic [OP_WIDTH-1:0] op_event;
  logic [OP_WIDTH-1:0] op_enable;
  logic [OV_WIDTH-1:0] ov_event;
  logic [OV_WIDTH-1:0] ov_enable;
  logic [7:0] se_event;
  logic [7:0] se_enable;
  logic [7:0] se_set;
  logic [7:0] sre_q;
  logic op_summary;
  logic se_summary;
  logic ov_summary;
  logic [7:0] summary_byte;
  logic master_summary_flag;
  logic request_service_flag_q;
  logic request_service_flag_d;
  logic [7:0] poll_byte;
  logic [15:0] rd_mux;
  logic master_summary_q;
  logic master_rise;
  logic [7:0] summary_read;

  wire sel_summary = reg_sel_in == isr_pkg::ISR_REG_SUMMARY;
  wire sel_sre = reg_sel_in == isr_pkg::ISR_REG_SRE;
  wire sel_stdevt = reg_sel_in == isr_pkg::ISR_REG_STDEVT;
  wire sel_ese = reg_sel_in == isr_pkg::ISR_REG_ESE;
  wire sel_opcond = reg_sel_in == isr_pkg::ISR_REG_OPCOND;
  wire sel_opevt = reg_sel_in == isr_pkg::ISR_REG_OPEVT;
  wire sel_open = reg_sel_in == isr_pkg::ISR_REG_OPEN;
  wire sel_ptr = reg_sel_in == isr_pkg::ISR_REG_PTR;
  wire sel_ntr = reg_sel_in == isr_pkg::ISR_REG_NTR;
  wire sel_ovevt = reg_sel_in == isr_pkg::ISR_REG_OVEVT;
  wire sel_oven = reg_sel_in == isr_pkg::ISR_REG_OVEN;

  // Enables change only on an explicit write, so writing 0 clears them
  wire wr_sre = reg_wr_in & sel_sre;
  wire wr_ese = reg_wr_in & sel_ese;
  wire wr_open = reg_wr_in & sel_open;
  wire wr_ptr = reg_wr_in & sel_ptr;
  wire wr_ntr = reg_wr_in & sel_ntr;
  wire wr_oven = reg_wr_in & sel_oven;

  // Read-to-clear strobes; the read itself still returns the old contents
  wire clr_std = clear_status_in | (reg_rd_in & sel_stdevt);
  wire clr_op = clear_status_in | (reg_rd_in & sel_opevt);
  wire clr_ov = clear_status_in | (reg_rd_in & sel_ovevt);

  // Only spot, sweep and calibration drive condition bits
  always_comb begin
    op_cond = '0;
    op_cond[isr_pkg::OC_SPOT_POS] = op_status_in.spot_busy;
    op_cond[isr_pkg::OC_SWEEP_POS] = op_status_in.sweep_busy;
    op_cond[isr_pkg::OC_CAL_POS] = op_status_in.cal_busy;
  end

  // Edge filters on the condition register
  assign op_set = (op_cond & ~op_cond_q & ptr_q)
    | (~op_cond & op_cond_q & ntr_q);

  always_comb begin
    se_set = '0;
    se_set[isr_pkg::SE_SYNTAX_ERR_POS] = std_events_in.syntax_error;
    se_set[isr_pkg::SE_EXEC_ERR_POS] = std_events_in.execution_error;
    se_set[isr_pkg::SE_DEVICE_ERR_POS] = std_events_in.device_error;
    se_set[isr_pkg::SE_QUERY_ERR_POS] = std_events_in.query_error;
    se_set[isr_pkg::SE_OP_COMPLETE_POS] = std_events_in.op_complete;
  end

  // Power-on bit comes only from the reset value, never set again
  isr_event_reg #(
    .WIDTH(8),
    .RESET_VAL(isr_pkg::SE_RESET)
  ) u_std_event (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(se_set),
    .clear_in(clr_std),
    .wr_en_in(wr_ese),
    .wr_data_in(reg_wdata_in[7:0]),
    .event_out(se_event),
    .enable_out(se_enable),
    .summary_out(se_summary)
  );

  isr_event_reg #(
    .WIDTH(OP_WIDTH),
    .RESET_VAL('0)
  ) u_op_event (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(op_set),
    .clear_in(clr_op),
    .wr_en_in(wr_open),
    .wr_data_in(reg_wdata_in[OP_WIDTH-1:0]),
    .event_out(op_event),
    .enable_out(op_enable),
    .summary_out(op_summary)
  );

  isr_event_reg #(
    .WIDTH(OV_WIDTH),
    .RESET_VAL('0)
  ) u_ov_event (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .set_in(overload_events_in),
    .clear_in(clr_ov),
    .wr_en_in(wr_oven),
    .wr_data_in(reg_wdata_in[OV_WIDTH-1:0]),
    .event_out(ov_event),
    .enable_out(ov_enable),
    .summary_out(ov_summary)
  );

  // Status byte summary bits; bits 6, 3, 2, 1 are zero here
  always_comb begin
    summary_byte = '0;
    summary_byte[isr_pkg::SB_OPERATION_POS] = op_summary;
    summary_byte[isr_pkg::SB_STD_EVENT_POS] = se_summary;
    summary_byte[isr_pkg::SB_MSG_AVAIL_POS] = message_available_in;
    summary_byte[isr_pkg::SB_OVERLOAD_POS] = ov_summary;
  end

  // Enable bit 6 is ignored: the master summary cannot feed itself
  assign master_summary_flag = |(summary_byte & sre_q);

  // Request flag rises with a new request, a poll cancels it.
  // A new request needs the master summary to drop and rise again,
  // else a standing summary would undo the poll on the next cycle.
  // A poll in the cycle of a fresh request keeps the flag set.
  assign master_rise = master_summary_flag & ~master_summary_q;
  assign request_service_flag_d = master_rise
    | (request_service_flag_q & ~serial_poll_in & master_summary_flag);

  always_comb begin
    poll_byte = summary_byte;
    poll_byte[isr_pkg::SB_MASTER_POS] = request_service_flag_q;
  end

  // Query view of the status byte shows the live master summary in bit 6
  always_comb begin
    summary_read = summary_byte;
    summary_read[isr_pkg::SB_MASTER_POS] = master_summary_flag;
  end

  // Unused bits of standard events always read zero
  wire [7:0] se_unused_mask = (8'h01 << isr_pkg::SE_USER_REQ_POS) | (8'h01 << isr_pkg::SE_REQ_CONTROL_POS);
  wire [7:0] se_read = se_event & ~se_unused_mask;

  always_comb begin
    rd_mux = '0;
    if (sel_summary) begin
      rd_mux[7:0] = summary_read;
    end else if (sel_sre) begin
      rd_mux[7:0] = sre_q;
    end else if (sel_stdevt) begin
      rd_mux[7:0] = se_read;
    end else if (sel_ese) begin
      rd_mux[7:0] = se_enable;
    end else if (sel_opcond) begin
      rd_mux = op_cond;
    end else if (sel_opevt) begin
      rd_mux = op_event;
    end else if (sel_open) begin
      rd_mux = op_enable;
    end else if (sel_ptr) begin
      rd_mux = ptr_q;
    end else if (sel_ntr) begin
      rd_mux = ntr_q;
    end else if (sel_ovevt) begin
      rd_mux[OV_WIDTH-1:0] = ov_event;
    end else if (sel_oven) begin
      rd_mux[OV_WIDTH-1:0] = ov_enable;
    end
  end

  // Host-written enable and filter registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sre_q <= isr_pkg::BYTE_RESET;
      ptr_q <= isr_pkg::WORD_RESET;
      ntr_q <= isr_pkg::WORD_RESET;
    end else begin
      if (wr_sre) begin
        sre_q <= reg_wdata_in[7:0];
      end
      if (wr_ptr) begin
        ptr_q <= reg_wdata_in;
      end
      if (wr_ntr) begin
        ntr_q <= reg_wdata_in;
      end
    end
  end

  // History for the edge detectors; filters also reset to 0,
  // so leaving reset with a condition already high makes no event
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      op_cond_q <= isr_pkg::WORD_RESET;
      master_summary_q <= 1'b0;
    end else begin
      op_cond_q <= op_cond;
      master_summary_q <= master_summary_flag;
    end
  end

  // Service request output is the request flag itself
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      request_service_flag_q <= 1'b0;
      service_request_out <= 1'b0;
    end else begin
      request_service_flag_q <= request_service_flag_d;
      service_request_out <= request_service_flag_d;
    end
  end

  // Plain binary words; the parser forms the weight sums.
  // Read data holds until the next read.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= isr_pkg::WORD_RESET;
      reg_rvalid_out <= 1'b0;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux;
      end
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // Poll byte is taken at the poll, before the poll clears the flag
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      poll_byte_out <= isr_pkg::BYTE_RESET;
      poll_valid_out <= 1'b0;
    end else begin
      if (serial_poll_in) begin
        poll_byte_out <= poll_byte;
      end
      poll_valid_out <= serial_poll_in;
    end
  end
endmodule
`default_nettype wire

//--- test/isr_status_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module isr_status_top_properties (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic message_available_in,
  input wire logic serial_poll_in,
  input wire logic reg_rd_in,
  input wire isr_pkg::isr_reg_e reg_sel_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [7:0] poll_byte_out,
  input wire logic poll_valid_out,
  input wire logic service_request_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire rd_sum = reg_rd_in && reg_sel_in == isr_pkg::ISR_REG_SUMMARY;
  wire rd_std = reg_rd_in && reg_sel_in == isr_pkg::ISR_REG_STDEVT;
  wire rd_cond = reg_rd_in && reg_sel_in == isr_pkg::ISR_REG_OPCOND;
  AST_READ_ANSWER: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
  AST_POLL_ANSWER: assert property (serial_poll_in |=> poll_valid_out) else $error("poll not answered");
  AST_POLL_BIT6: assert property (serial_poll_in |=> poll_byte_out[6] == $past(service_request_out))
    else $error("poll request bit wrong");
  AST_POLL_CANCEL: assert property (serial_poll_in && service_request_out |=> !service_request_out)
    else $error("poll kept request");
  AST_SUM_ZERO: assert property (rd_sum |=> reg_rdata_out[15:8] == 8'h00 && reg_rdata_out[3:1] == 3'h0)
    else $error("unused status bits set");
  AST_STD_ZERO: assert property (rd_std |=> !reg_rdata_out[6] && !reg_rdata_out[1])
    else $error("unused event bits set");
  AST_COND_ZERO: assert property (rd_cond |=> (reg_rdata_out & 16'hebfe) == 16'h0000)
    else $error("unused condition bits set");
  AST_SUM_MSG: assert property (rd_sum |=> reg_rdata_out[4] == $past(message_available_in))
    else $error("message bit wrong");
  AST_SUM_MASTER: assert property (rd_sum |=> !reg_rdata_out[6] || (reg_rdata_out[7:0] & 8'hb1) != 8'h00)
    else $error("master summary without source");
  cover property (rd_std ##1 reg_rdata_out[7]);
  cover property ($rose(service_request_out));
  cover property (poll_valid_out && poll_byte_out[6]);
endmodule
bind isr_status_top isr_status_top_properties u_isr_status_top_properties (
  .clock_in(clock_in),
  .sys_rst_in(sys_rst_in),
  .message_available_in(message_available_in),
  .serial_poll_in(serial_poll_in),
  .reg_rd_in(reg_rd_in),
  .reg_sel_in(reg_sel_in),
  .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out),
  .poll_byte_out(poll_byte_out),
  .poll_valid_out(poll_valid_out),
  .service_request_out(service_request_out)
);
`default_nettype wire

//--- test/isr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module isr_host_model (
  input wire logic clock_in,
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  input wire logic [7:0] poll_byte_in,
  input wire logic poll_valid_in,
  output logic reg_wr_out = 1'b0,
  output logic reg_rd_out = 1'b0,
  output isr_pkg::isr_reg_e reg_sel_out = isr_pkg::ISR_REG_SUMMARY,
  output logic [15:0] reg_wdata_out = 16'h5a5a,
  output logic poll_out = 1'b0,
  output logic clear_out = 1'b0
);
  // Data lines show garbage once a write is over
  task automatic wr(input isr_pkg::isr_reg_e s, input logic [15:0] v);
    @(posedge clock_in);
    reg_sel_out <= s;
    reg_wdata_out <= v;
    reg_wr_out <= 1'b1;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~v;
  endtask
  task automatic rd(input isr_pkg::isr_reg_e s, output logic [15:0] v);
    @(posedge clock_in);
    reg_sel_out <= s;
    reg_rd_out <= 1'b1;
    @(posedge clock_in);
    reg_rd_out <= 1'b0;
    #1;
    v = reg_rvalid_in ? reg_rdata_in : 16'hxxxx;
  endtask
  // Poll when p is high, clear-status otherwise
  task automatic cmd(input logic p, output logic [7:0] b);
    @(posedge clock_in);
    poll_out <= p;
    clear_out <= !p;
    @(posedge clock_in);
    poll_out <= 1'b0;
    clear_out <= 1'b0;
    #1;
    b = poll_valid_in ? poll_byte_in : 8'hxx;
  endtask
endmodule
`default_nettype wire

//--- test/test_isr_status_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_isr_status_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  isr_pkg::isr_std_events_s std_ev = '0;
  isr_pkg::isr_op_status_s op_st = '0;
  logic [15:0] ovl = '0;
  logic msg = 1'b0;
  logic wr, rd, pl, cl, rv, pv, sreq;
  isr_pkg::isr_reg_e sel;
  logic [15:0] wd, rdat, d;
  logic [7:0] pb, b;
  int fail_count = 0, checks_done = 0, x = 48061, ex = 0, i;
  always #5 clock_in = ~clock_in;
  isr_status_top u_isr_status_top (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .std_events_in(std_ev),
    .op_status_in(op_st), .overload_events_in(ovl), .message_available_in(msg), .clear_status_in(cl),
    .serial_poll_in(pl), .reg_wr_in(wr), .reg_rd_in(rd), .reg_sel_in(sel), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .poll_byte_out(pb), .poll_valid_out(pv), .service_request_out(sreq));
  isr_host_model u_isr_host_model (.clock_in(clock_in), .reg_rdata_in(rdat), .reg_rvalid_in(rv), .poll_byte_in(pb),
    .poll_valid_in(pv), .reg_wr_out(wr), .reg_rd_out(rd), .reg_sel_out(sel), .reg_wdata_out(wd), .poll_out(pl),
    .clear_out(cl));
  function automatic int nxt(input int v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rdc(input isr_pkg::isr_reg_e s, input logic [15:0] e);
    u_isr_host_model.rd(s, d);
    chk(d, e);
  endtask
  task automatic pulse(input logic [4:0] s, input logic [15:0] o);
    @(posedge clock_in);
    std_ev <= s;
    ovl <= o;
    @(posedge clock_in);
    std_ev <= '0;
    ovl <= '0;
  endtask
  // Conditions are levels; give the filter a few cycles per step
  task automatic setop(input logic [2:0] v);
    @(posedge clock_in);
    op_st <= v;
    repeat (3) @(posedge clock_in);
  endtask
  task automatic wait_req;
    for (i = 0; i < 8 && sreq !== 1'b1; i++) @(posedge clock_in);
    if (sreq !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rdc(isr_pkg::ISR_REG_STDEVT, 16'h0080);
    rdc(isr_pkg::ISR_REG_STDEVT, 16'h0000);
    for (int k = 0; k < 24; k++) begin
      x = nxt(x);
      pulse(x[4:0], 16'h0000);
      ex |= {x[4:1], 1'b0, x[0]};
      if (x[5] || k == 23) begin
        rdc(isr_pkg::ISR_REG_STDEVT, ex[15:0]);
        ex = 0;
      end
    end
    u_isr_host_model.wr(isr_pkg::ISR_REG_SRE, 16'h0020);
    u_isr_host_model.wr(isr_pkg::ISR_REG_ESE, 16'h0020);
    pulse(5'h10, 16'h0000);
    wait_req();
    u_isr_host_model.cmd(1'b1, b);
    chk({8'h00, b}, 16'h0060);
    chk({15'h0000, sreq}, 16'h0000);
    rdc(isr_pkg::ISR_REG_SUMMARY, 16'h0060);
    // Summary still stands: a polled request must not come back by itself
    repeat (4) @(posedge clock_in);
    chk({15'h0000, sreq}, 16'h0000);
    rdc(isr_pkg::ISR_REG_STDEVT, 16'h0020);
    rdc(isr_pkg::ISR_REG_SUMMARY, 16'h0000);
    u_isr_host_model.wr(isr_pkg::ISR_REG_ESE, 16'h0000);
    rdc(isr_pkg::ISR_REG_ESE, 16'h0000);
    u_isr_host_model.wr(isr_pkg::ISR_REG_SRE, 16'h0000);
    rdc(isr_pkg::ISR_REG_SRE, 16'h0000);
    u_isr_host_model.wr(isr_pkg::ISR_REG_PTR, 16'h1000);
    u_isr_host_model.wr(isr_pkg::ISR_REG_NTR, 16'h0400);
    u_isr_host_model.wr(isr_pkg::ISR_REG_OPEN, 16'h1400);
    setop(3'b100);
    setop(3'b010);
    setop(3'b011);
    rdc(isr_pkg::ISR_REG_OPCOND, 16'h0401);
    rdc(isr_pkg::ISR_REG_OPCOND, 16'h0401);
    setop(3'b000);
    rdc(isr_pkg::ISR_REG_SUMMARY, 16'h0080);
    rdc(isr_pkg::ISR_REG_OPEVT, 16'h1400);
    rdc(isr_pkg::ISR_REG_OPEVT, 16'h0000);
    setop(3'b100);
    pulse(5'h01, 16'h0000);
    u_isr_host_model.cmd(1'b0, b);
    rdc(isr_pkg::ISR_REG_STDEVT, 16'h0000);
    rdc(isr_pkg::ISR_REG_OPEVT, 16'h0000);
    u_isr_host_model.wr(isr_pkg::ISR_REG_OVEN, 16'h0001);
    @(posedge clock_in);
    msg <= 1'b1;
    pulse(5'h00, 16'h0003);
    rdc(isr_pkg::ISR_REG_SUMMARY, 16'h0011);
    u_isr_host_model.wr(isr_pkg::ISR_REG_SRE, 16'h0011);
    wait_req();
    chk({15'h0000, sreq}, 16'h0001);
    rdc(isr_pkg::ISR_REG_OVEVT, 16'h0003);
    rdc(isr_pkg::isr_reg_e'(4'hf), 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
